// ==== design/atc_event_logic.v ====
/*
  Event latching for eight auto-triggered DMA channels: trigger-word
  detection on parameter-RAM writes and link updates, event flags,
  missed events, secondary (queued) events, enable set/clear, global and
  shadow register access, a transfer request port and an interrupt.
  Assumes all inputs are synchronous to clk, and that the transfer
  controller side holds tr_req_ready as a plain level.
*/
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "atc_defs.vh"

// Notes on behaviour
// - Write to a channel's mapped trigger word sets its event flag.
// - A link update hitting the mapped entry also sets the event flag.
// - Only enabled channels latch triggers; disabled ones ignore them.
// - Set flags compete by priority for a transfer request submission.
// - A set and a clear in the same cycle: the set wins.
// - A trigger on a channel whose flag is still set marks it missed.
// - Set meeting clear on a clear flag leaves it set and unqueued.
// - Hardware clears a flag only once its request was submitted.
// - Flag and enable registers use bits 7-0; bits 31-8 read zero.
// - Enable zero: triggers neither seen nor latched; one: latched.
// - Enables are read-only; changed only by set and clear registers.
// - Channel registers reachable globally and via gated shadow regions.
// - Writing one to enable-clear clears the enable; zero does nothing.
// - Writing one to enable-set sets the enable; zero does nothing.
// - While a channel's secondary bit is set it is not prioritised.
// - Secondary-clear one clears secondary bit and event flag together.
module atc_event_logic #(
  parameter CH = 8,
  parameter IDX_W = 3
) (
  input wire clk,
  input wire reset_n,
  input wire [`ATC_ADDR_W-1:0] reg_addr,
  input wire [`ATC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`ATC_DATA_W-1:0] reg_rdata,
  input wire pram_wr,
  input wire [`ATC_ENTRY_W-1:0] pram_wr_entry,
  input wire [`ATC_WORD_W-1:0] pram_wr_word,
  input wire link_upd,
  input wire [`ATC_ENTRY_W-1:0] link_upd_entry,
  output reg tr_req_valid,
  output reg [IDX_W-1:0] tr_req_channel,
  output reg [`ATC_ENTRY_W-1:0] tr_req_entry,
  input wire tr_req_ready,
  output wire irq
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Entry field of a mapping value
  function [`ATC_ENTRY_W-1:0] map_entry;
    input [`ATC_MAP_W-1:0] map;
    begin
      map_entry = map[`ATC_ENTRY_MSB:`ATC_ENTRY_LSB];
    end
  endfunction

  // Trigger word field of a mapping value
  function [`ATC_WORD_W-1:0] map_word;
    input [`ATC_MAP_W-1:0] map;
    begin
      map_word = map[`ATC_WORD_MSB:`ATC_WORD_LSB];
    end
  endfunction

  // Channel vector placed in the low bits of a bus word
  function [`ATC_DATA_W-1:0] to_word;
    input [CH-1:0] bits;
    begin
      to_word = {{(`ATC_DATA_W - CH){1'b0}}, bits};
    end
  endfunction

  // Channel bits of a write-one register, or none when not addressed
  function [CH-1:0] strobe_bits;
    input sel;
    input [CH-1:0] bits;
    begin
      strobe_bits = sel ? bits : {CH{1'b0}};
    end
  endfunction

  // Interrupt register placed in the low bits of a bus word
  function [`ATC_DATA_W-1:0] int_word;
    input [`ATC_INT_W-1:0] bits;
    begin
      int_word = {{(`ATC_DATA_W - `ATC_INT_W){1'b0}}, bits};
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [CH-1:0] flags_reg;
  reg [CH-1:0] flags_next;
  reg [CH-1:0] enables_reg;
  reg [CH-1:0] enables_next;
  reg [CH-1:0] secondary_reg;
  reg [CH-1:0] secondary_next;
  reg [CH-1:0] missed_reg;
  reg [CH-1:0] missed_next;
  reg [`ATC_INT_W-1:0] int_status_reg;
  reg [`ATC_INT_W-1:0] int_status_next;
  reg [`ATC_INT_W-1:0] int_mask_reg;
  reg [`ATC_MAP_W-1:0] map_reg [0:CH-1];
  reg [CH-1:0] rae_reg [0:`ATC_REGIONS-1];
  reg [`ATC_DATA_W-1:0] rdata_next;

  // Separate loop indices keep each process the only writer of its own
  integer i;
  integer m;
  integer r;

  // ----------------------------------------------------------------------
  // Address decode and shadow gating
  // ----------------------------------------------------------------------
  wire shadow = reg_addr[`ATC_SHADOW_BIT];
  wire [`ATC_REGION_MSB-`ATC_REGION_LSB:0] region =
    reg_addr[`ATC_REGION_MSB:`ATC_REGION_LSB];
  wire [`ATC_OFF_MSB:0] off = reg_addr[`ATC_OFF_MSB:0];
  wire [IDX_W-1:0] map_idx = reg_addr[`ATC_MAP_IDX_MSB:`ATC_MAP_IDX_LSB];
  wire [`ATC_RAE_IDX_MSB-`ATC_RAE_IDX_LSB:0] rae_idx =
    reg_addr[`ATC_RAE_IDX_MSB:`ATC_RAE_IDX_LSB];
  wire map_hit = !shadow &&
    (off[`ATC_MAP_SEL_MSB:`ATC_MAP_SEL_LSB] == `ATC_MAP_SEL);
  wire rae_hit = !shadow &&
    (off[`ATC_RAE_SEL_MSB:`ATC_RAE_SEL_LSB] == `ATC_RAE_SEL);

  // Shadow accesses only see channels granted to their region
  wire [CH-1:0] access_mask = shadow ? rae_reg[region] : {CH{1'b1}};
  wire [CH-1:0] wbits = reg_wdata[CH-1:0] & access_mask;

  // Write strobes for the channel registers, both ranges
  wire wr_en_clr = reg_wr && (off == `ATC_OFF_EN_CLEAR);
  wire wr_en_set = reg_wr && (off == `ATC_OFF_EN_SET);
  wire wr_sec_clr = reg_wr && (off == `ATC_OFF_SEC_CLEAR);
  wire wr_missed_clr = reg_wr && (off == `ATC_OFF_MISSED_CLR);
  // Write strobes for global-only registers
  wire wr_int_status = reg_wr && !shadow && (off == `ATC_OFF_INT_STATUS);
  wire wr_int_mask = reg_wr && !shadow && (off == `ATC_OFF_INT_MASK);

  // Write-one bits per register; zero bits leave a channel alone
  wire [CH-1:0] en_clr_bits = strobe_bits(wr_en_clr, wbits);
  wire [CH-1:0] en_set_bits = strobe_bits(wr_en_set, wbits);
  wire [CH-1:0] sec_clr_bits = strobe_bits(wr_sec_clr, wbits);
  wire [CH-1:0] missed_clr_bits = strobe_bits(wr_missed_clr, wbits);

  // ----------------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------------
  reg [CH-1:0] hit;

  // Link updates compare the entry only; the word is not part of it
  // Compare each channel's mapping against both write sources
  always @* begin
    hit = {CH{1'b0}};
    for (i = 0; i < CH; i = i + 1) begin
      hit[i] = (pram_wr && (pram_wr_entry == map_entry(map_reg[i])) &&
                (pram_wr_word == map_word(map_reg[i]))) ||
               (link_upd &&
                (link_upd_entry == map_entry(map_reg[i])));
    end
  end

  // Disabled channels drop the trigger entirely
  wire [CH-1:0] trig = hit & enables_reg;
  // A trigger landing on a still-set flag is lost
  wire [CH-1:0] missed_set = trig & flags_reg;

  // ----------------------------------------------------------------------
  // Prioritisation and transfer request stage
  // ----------------------------------------------------------------------
  wire [CH-1:0] eligible = flags_reg & ~secondary_reg;
  wire [CH-1:0] grant;
  wire [IDX_W-1:0] grant_idx;
  wire grant_any;

  atc_prio_pick #(
    .N(CH),
    .IDX_W(IDX_W)
  ) u_pick (
    .req(eligible),
    .grant(grant),
    .idx(grant_idx),
    .any(grant_any)
  );

  wire submit = tr_req_valid && tr_req_ready;
  wire slot_free = !tr_req_valid || tr_req_ready;
  wire take = grant_any && slot_free;
  wire [CH-1:0] take_bits = take ? grant : {CH{1'b0}};
  reg [CH-1:0] sub_bits;

  // One-hot of the channel whose request leaves this cycle
  always @* begin
    sub_bits = {CH{1'b0}};
    if (submit) begin
      sub_bits[tr_req_channel] = 1'b1;
    end
  end

  // Request register: loaded from the winner whenever the slot frees
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tr_req_valid <= 1'b0;
      tr_req_channel <= {IDX_W{1'b0}};
      tr_req_entry <= {`ATC_ENTRY_W{1'b0}};
    end else if (slot_free) begin
      tr_req_valid <= grant_any;
      tr_req_channel <= grant_idx;
      tr_req_entry <= map_entry(map_reg[grant_idx]);
    end
  end

  // ----------------------------------------------------------------------
  // Next state of the channel vectors
  // ----------------------------------------------------------------------
  always @* begin
    // Set wins over hardware and software clears
    flags_next = (flags_reg & ~(sub_bits | sec_clr_bits)) | trig;
    // Secondary bit marks the event as queued until it is submitted
    secondary_next = (secondary_reg & ~(sub_bits | sec_clr_bits)) |
                     take_bits;
    // Enables move only through the set and clear registers
    enables_next = (enables_reg | en_set_bits) & ~en_clr_bits;
    // Missed bits are sticky; a new miss beats a clear
    missed_next = (missed_reg & ~missed_clr_bits) | missed_set;
    // Interrupt causes: any missed event, any submission
    int_status_next = int_status_reg;
    if (wr_int_status) begin
      int_status_next = int_status_reg & ~reg_wdata[`ATC_INT_W-1:0];
    end
    if (|missed_set) begin
      int_status_next[`ATC_INT_MISSED] = 1'b1;
    end
    if (submit) begin
      int_status_next[`ATC_INT_SUBMIT] = 1'b1;
    end
  end

  // Channel vectors and interrupt state
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // All channels leave reset disabled, idle and unqueued
      flags_reg <= `ATC_CH_RESET;
      secondary_reg <= `ATC_CH_RESET;
      enables_reg <= `ATC_CH_RESET;
      missed_reg <= `ATC_CH_RESET;
      int_status_reg <= `ATC_INT_RESET;
      int_mask_reg <= `ATC_INT_RESET;
    end else begin
      flags_reg <= flags_next;
      secondary_reg <= secondary_next;
      enables_reg <= enables_next;
      missed_reg <= missed_next;
      int_status_reg <= int_status_next;
      if (wr_int_mask) begin
        int_mask_reg <= reg_wdata[`ATC_INT_W-1:0];
      end
    end
  end

  // Level interrupt while any unmasked cause is pending
  assign irq = |(int_status_reg & int_mask_reg);

  // ----------------------------------------------------------------------
  // Mapping and region access enable registers (global range only)
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (m = 0; m < CH; m = m + 1) begin
        map_reg[m] <= `ATC_MAP_RESET;
      end
    end else if (reg_wr && map_hit) begin
      map_reg[map_idx] <= reg_wdata[`ATC_MAP_W-1:0];
    end
  end

  // Region access enables gate the shadow ranges per channel
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (r = 0; r < `ATC_REGIONS; r = r + 1) begin
        rae_reg[r] <= `ATC_CH_RESET;
      end
    end else if (reg_wr && rae_hit) begin
      rae_reg[rae_idx] <= reg_wdata[CH-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read path: data stands in the cycle after the read strobe
  // ----------------------------------------------------------------------
  always @* begin
    rdata_next = `ATC_DATA_RESET;
    if (reg_rd) begin
      if (map_hit) begin
        rdata_next = {{(`ATC_DATA_W - `ATC_MAP_W){1'b0}}, map_reg[map_idx]};
      end else if (rae_hit) begin
        rdata_next = to_word(rae_reg[rae_idx]);
      end else begin
        case (off)
          `ATC_OFF_FLAGS: begin
            rdata_next = to_word(flags_reg & access_mask);
          end
          `ATC_OFF_ENABLES: begin
            rdata_next = to_word(enables_reg & access_mask);
          end
          `ATC_OFF_SECONDARY: begin
            rdata_next = to_word(secondary_reg & access_mask);
          end
          `ATC_OFF_MISSED: begin
            rdata_next = to_word(missed_reg & access_mask);
          end
          `ATC_OFF_INT_STATUS: begin
            if (!shadow) begin
              rdata_next = int_word(int_status_reg);
            end
          end
          `ATC_OFF_INT_MASK: begin
            if (!shadow) begin
              rdata_next = int_word(int_mask_reg);
            end
          end
          default: begin
            rdata_next = `ATC_DATA_RESET;
          end
        endcase
      end
    end
  end

  // Read data register; zero outside read answers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `ATC_DATA_RESET;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule

// ==== design/atc_defs.vh ====
/*
  Constants of the auto-triggered channel event logic: register offsets,
  field positions, reset values and address decode positions.
  Assumes it is included by bare name by the design files of this block.
*/
`ifndef ATC_DEFS_VH
`define ATC_DEFS_VH

// ----------------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------------
`define ATC_ADDR_W 12
`define ATC_DATA_W 32
`define ATC_OFF_MSB 8
`define ATC_SHADOW_BIT 11
`define ATC_REGION_MSB 10
`define ATC_REGION_LSB 9
`define ATC_REGIONS 4

// ----------------------------------------------------------------------
// Register offsets within a region (byte addresses, word aligned)
// ----------------------------------------------------------------------
`define ATC_OFF_FLAGS 9'h080
`define ATC_OFF_ENABLES 9'h084
`define ATC_OFF_EN_CLEAR 9'h088
`define ATC_OFF_EN_SET 9'h08c
`define ATC_OFF_SECONDARY 9'h090
`define ATC_OFF_SEC_CLEAR 9'h094
`define ATC_OFF_MISSED 9'h098
`define ATC_OFF_MISSED_CLR 9'h09c
`define ATC_OFF_INT_STATUS 9'h0a0
`define ATC_OFF_INT_MASK 9'h0a4

// Channel mapping block at 0x100..0x11c, index in offset bits 4:2
`define ATC_MAP_SEL_MSB 8
`define ATC_MAP_SEL_LSB 5
`define ATC_MAP_SEL 4'h8
`define ATC_MAP_IDX_MSB 4
`define ATC_MAP_IDX_LSB 2

// Region access enables at 0x140..0x14c, index in offset bits 3:2
`define ATC_RAE_SEL_MSB 8
`define ATC_RAE_SEL_LSB 4
`define ATC_RAE_SEL 5'h14
`define ATC_RAE_IDX_MSB 3
`define ATC_RAE_IDX_LSB 2

// ----------------------------------------------------------------------
// Channel mapping fields: parameter-RAM entry and trigger word
// ----------------------------------------------------------------------
`define ATC_MAP_W 14
`define ATC_ENTRY_W 9
`define ATC_ENTRY_MSB 13
`define ATC_ENTRY_LSB 5
`define ATC_WORD_W 3
`define ATC_WORD_MSB 4
`define ATC_WORD_LSB 2

// ----------------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------------
`define ATC_INT_W 2
`define ATC_INT_MISSED 0
`define ATC_INT_SUBMIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ATC_CH_RESET 8'h00
`define ATC_MAP_RESET 14'h0000
`define ATC_INT_RESET 2'h0
`define ATC_DATA_RESET 32'h0000_0000

`endif

// ==== design/atc_prio_pick.v ====
/*
  Fixed-priority picker: the lowest numbered requesting channel wins.
  Assumes a purely combinational use; the caller registers the result.
*/
`timescale 1ns/1ps

module atc_prio_pick #(
  parameter N = 8,
  parameter IDX_W = 3
) (
  input wire [N-1:0] req,
  output reg [N-1:0] grant,
  output reg [IDX_W-1:0] idx,
  output reg any
);

  integer i;

  // ----------------------------------------------------------------------
  // Scan from the top so the lowest index is the last to be taken
  // ----------------------------------------------------------------------
  always @* begin
    grant = {N{1'b0}};
    idx = {IDX_W{1'b0}};
    any = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        grant = {N{1'b0}};
        grant[i] = 1'b1;
        idx = i[IDX_W-1:0];
        any = 1'b1;
      end
    end
  end

endmodule

// ==== bench/atc_monitor.sv ====
/*
  Port checker for the auto-triggered channel event logic.
  Assumes binding to atc_event_logic and a single clock domain.
*/
`timescale 1ns/1ps

module atc_monitor #(
  parameter IDX_W = 3
) (
  input wire clk,
  input wire reset_n,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire tr_req_valid,
  input wire [IDX_W-1:0] tr_req_channel,
  input wire [8:0] tr_req_entry,
  input wire tr_req_ready
);
  // All checks share the one clock and its reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_rsvd_zero: assert property (
    $past(reg_rd) && $past(reg_addr) inside {12'h080, 12'h084}
    |-> reg_rdata[31:8] == 24'h0)
    else $error("reserved bits not zero");
  a_shadow_map: assert property (
    $past(reg_rd) && $past(reg_addr[11]) && $past(reg_addr[8:5]) == 4'h8
    |-> reg_rdata == 32'h0)
    else $error("mapping visible through shadow");
  a_req_hold: assert property (
    tr_req_valid && !tr_req_ready |=> tr_req_valid && $stable(tr_req_entry))
    else $error("request dropped before submission");
  a_chan_hold: assert property (
    tr_req_valid && !tr_req_ready |=> $stable(tr_req_channel))
    else $error("request channel changed while pending");
  a_no_repeat: assert property (
    tr_req_valid && tr_req_ready
    |=> !tr_req_valid || tr_req_channel != $past(tr_req_channel))
    else $error("queued channel prioritised again");
  a_en_clear: assert property (
    reg_wr && reg_addr == 12'h088 && reg_wdata[7:0] == 8'hff
    ##2 reg_rd && reg_addr == 12'h084 |=> reg_rdata[7:0] == 8'h00)
    else $error("enable clear did not clear");
  a_en_set: assert property (
    reg_wr && reg_addr == 12'h08c && reg_wdata[7:0] == 8'hff
    ##2 reg_rd && reg_addr == 12'h084 |=> reg_rdata[7:0] == 8'hff)
    else $error("enable set did not set");
endmodule

bind atc_event_logic atc_monitor #(.IDX_W(IDX_W)) i_atc_monitor (
  .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .tr_req_valid, .tr_req_channel, .tr_req_entry, .tr_req_ready);

// ==== bench/atc_tc_model.sv ====
/*
  Transfer controller stand-in: takes requests after a chosen delay.
  Assumes the bench sets stall and lat synchronously to clk.
*/
`timescale 1ns/1ps

module atc_tc_model (
  input wire clk,
  input wire reset_n,
  input wire tr_req_valid,
  input wire stall,
  input wire [1:0] lat,
  output reg tr_req_ready
);
  reg [1:0] cnt_reg;

  // Ready pulses one cycle after lat waiting cycles, never while stalled
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tr_req_ready <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (tr_req_valid && !tr_req_ready && !stall) begin
      if (cnt_reg >= lat) begin
        tr_req_ready <= 1'b1;
        cnt_reg <= 2'h0;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end else begin
      tr_req_ready <= 1'b0;
    end
  end
endmodule

// ==== bench/test_autotrig_channel_event_logic.sv ====
/*
  Self-checking bench for the auto-triggered channel event logic.
  Assumes atc_event_logic, atc_tc_model and the bound checker.
*/
`timescale 1ns/1ps

module test_autotrig_channel_event_logic;
  logic clk, reset_n, reg_wr, reg_rd, pram_wr, link_upd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8:0] pram_wr_entry, link_upd_entry, tr_req_entry;
  logic [2:0] pram_wr_word, tr_req_channel;
  logic tr_req_valid, tr_req_ready, irq, stall;
  logic [1:0] lat;
  logic [7:0] en, flg, sec, mis;
  logic [8:0] ent [8];
  logic [2:0] wd [8];
  int num_errors, cmp_count, k, c;
  int order[$];

  atc_event_logic i_atc_event_logic (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pram_wr(pram_wr),
    .pram_wr_entry(pram_wr_entry), .pram_wr_word(pram_wr_word),
    .link_upd(link_upd), .link_upd_entry(link_upd_entry),
    .tr_req_valid(tr_req_valid), .tr_req_channel(tr_req_channel),
    .tr_req_entry(tr_req_entry), .tr_req_ready(tr_req_ready), .irq(irq));
  atc_tc_model i_atc_tc_model (.clk(clk), .reset_n(reset_n),
    .tr_req_valid(tr_req_valid), .stall(stall), .lat(lat),
    .tr_req_ready(tr_req_ready));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // One idle cycle so a following strobe is a fresh assignment
    @(posedge clk);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge clk);
  endtask

  // Trigger a channel, optionally with a same-cycle secondary clear
  task trig(input int ch, input bit lk, input bit cl, input bit bad);
    pram_wr <= !lk;
    link_upd <= lk;
    pram_wr_entry <= ent[ch];
    link_upd_entry <= ent[ch];
    pram_wr_word <= wd[ch] + 3'(bad);
    if (cl) begin
      reg_addr <= 12'h094;
      reg_wdata <= 32'h1 << ch;
      reg_wr <= 1'b1;
    end
    @(posedge clk);
    pram_wr <= 1'b0;
    link_upd <= 1'b0;
    reg_wr <= 1'b0;
    @(posedge clk);
    if (cl) sec[ch] = 1'b0;
    if (en[ch] && !bad) begin
      if (flg[ch]) mis[ch] = 1'b1;
      flg[ch] = 1'b1;
    end else if (cl) begin
      flg[ch] = 1'b0;
    end
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; reset_n = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0;
    reg_rd = 0; pram_wr = 0; pram_wr_entry = 0; pram_wr_word = 0;
    link_upd = 0; link_upd_entry = 0; stall = 1; lat = 0;
    num_errors = 0; cmp_count = 0; flg = 0; sec = 0; mis = 0;
    k = $urandom(2);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 4; k++) rdchk(12'h080 + 12'(4 * k), 32'h0);
    rdchk(12'h0fc, 32'h0);
    $display("test reset values done");
    en = 8'($urandom);
    wr(12'h08c, {24'($urandom), en});
    rdchk(12'h084, {24'h0, en});
    c = $urandom;
    wr(12'h088, 32'(c));
    en = en & ~c[7:0];
    rdchk(12'h084, {24'h0, en});
    wr(12'h084, 32'hff);
    rdchk(12'h084, {24'h0, en});
    wr(12'h088, 32'hff);
    rdchk(12'h084, 32'h0);
    wr(12'h08c, 32'hff);
    rdchk(12'h084, 32'hff);
    wr(12'h088, 32'h2);
    en = 8'hfd;
    $display("test enables done");
    for (k = 0; k < 8; k++) begin
      ent[k] = {3'(k), 6'($urandom)};
      wd[k] = 3'($urandom);
      wr(12'h100 + 12'(4 * k), {18'h0, ent[k], wd[k], 2'b00});
    end
    rdchk(12'h900, 32'h0);
    for (k = 0; k < 8; k++) trig(k, k == 5, 0, 0);
    trig(3, 0, 0, 1);
    trig(2, 0, 0, 0);
    trig(6, 1, 0, 0);
    sec = 8'h01;
    rdchk(12'h080, {24'h0, flg});
    rdchk(12'h098, {24'h0, mis});
    rdchk(12'h090, {24'h0, sec});
    chk(tr_req_valid, 1);
    chk(tr_req_channel, 0);
    chk(tr_req_entry, ent[0]);
    wr(12'h144, 32'h0f);
    rdchk(12'ha80, {28'h0, flg[3:0]});
    rdchk(12'hc80, 32'h0);
    trig(4, 0, 1, 0);
    wr(12'h094, 32'h10);
    flg[4] = 1'b0;
    rdchk(12'h080, {24'h0, flg});
    trig(4, 0, 1, 0);
    rdchk(12'h080, {24'h0, flg});
    rdchk(12'h098, {24'h0, mis});
    wr(12'h0a4, 32'h3);
    #1 chk(irq, 1);
    wr(12'h0a0, 32'h1);
    #1 chk(irq, 0);
    $display("test triggers done");
    for (k = 0; k < 8; k++) if (flg[k]) order.push_back(k);
    stall <= 1'b0;
    for (k = 0; k < 300 && order.size() > 0; k++) begin
      @(negedge clk);
      if (tr_req_valid && tr_req_ready) begin
        c = order.pop_front();
        chk(tr_req_channel, c);
        chk(tr_req_entry, ent[c]);
        lat <= 2'($urandom % 3);
      end
    end
    if (order.size() > 0) begin
      num_errors++;
      complete_run;
    end
    repeat (2) @(posedge clk);
    rdchk(12'h080, 32'h0);
    rdchk(12'h090, 32'h0);
    chk(tr_req_valid, 0);
    #1 chk(irq, 1);
    wr(12'h0a4, 32'h0);
    #1 chk(irq, 0);
    $display("test submission done");
    complete_run;
  end
endmodule
